// ==== core/queued_async_serial_receiver.sv ====
// Queued asynchronous serial receiver with an APB register slave.
`timescale 1ns/10ps
`include "serial_rx_defines.svh"
module queued_async_serial_receiver import serial_rx_pkg::*; #(
	parameter int DATA_W = 8
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic rxPin,
	input wire logic txqTake,
	input wire logic [3:0] txqTakeIdx,
	output logic irq
);
	// Bus decode.
	wire access = psel & penable;
	wire setup = psel & ~penable;
	wire wrEn = access & pwrite;
	wire rdEn = access & ~pwrite;
	wire hitCtrl = paddr == `SQ_CTRL_OFS;
	wire hitBaud = paddr == `SQ_BAUD_OFS;
	wire hitData = paddr == `SQ_DATA_OFS;
	wire hitSstat = paddr == `SQ_SSTAT_OFS;
	wire hitQstat = paddr == `SQ_QSTAT_OFS;
	wire hitIstat = paddr == `SQ_ISTAT_OFS;
	wire hitImask = paddr == `SQ_IMASK_OFS;
	// The queue window takes aligned words only.
	wire hitQueue = paddr >= `SQ_QBASE_OFS && paddr <= `SQ_QTOP_OFS && paddr[1:0] == 2'h0;
	wire hit = hitCtrl | hitBaud | hitData | hitSstat | hitQstat | hitIstat | hitImask | hitQueue;
	// The slave never waits; unmapped addresses answer with an error.
	assign pready = 1'b1;
	assign pslverr = access & ~hit;
	// Software-visible state.
	logic [3:0] ctrl_q; // Enable, parity enable, odd parity, test mode.
	logic [15:0] baud_q; // Clock cycles per oversample tick, minus one.
	logic [DATA_W-1:0] hold_q; // Parallel receive data holding register.
	logic full_q; // Holding register has an unread frame.
	rx_err_t err_q; // Errors of the frame in the holding register.
	logic [2:0] qFlag_q; // Lower rx full, upper tx empty, lower tx empty.
	logic [2:0] arm_q; // Flag was read as one; a zero write may clear it.
	logic [3:0] ptr_q; // Queue entry that the next frame lands in.
	logic [3:0] pend_q; // Pending decrementer, all ones means done.
	logic [2:0] iStat_q; // Sticky events: frame, error, queue flag.
	logic [2:0] iMask_q; // Event enables for the interrupt line.
	logic [DATA_W-1:0] rxq [16]; // Receive queue entries.
	logic [31:0] prdata_q;
	wire rxEn = ctrl_q[`SQ_CTRL_RXEN];
	wire parEn = ctrl_q[`SQ_CTRL_PAREN];
	wire parOdd = ctrl_q[`SQ_CTRL_PARODD];
	wire testMode = ctrl_q[`SQ_CTRL_TEST];
	// Receiver timing and bit engine.
	rx_state_t state_q;
	logic [15:0] div_q; // Divider toward the next oversample tick.
	logic [3:0] phase_q; // Oversample position inside one bit time.
	logic [1:0] samp_q; // First two of the three votes.
	logic [DATA_W-1:0] shift_q; // Serial shifter, hidden from the bus.
	logic [2:0] bitCnt_q;
	logic parBit_q;
	logic noiseAcc_q;
	logic rxPrev_q;
	wire tick = div_q == 16'h0000;
	wire startEdge = rxPrev_q & ~rxPin;
	wire voteNow = tick && phase_q == `SQ_PH_VOTE;
	// Two of three samples decide the bit; any disagreement is noise.
	wire vote = (samp_q[0] & samp_q[1]) | (samp_q[0] & rxPin) | (samp_q[1] & rxPin);
	wire noisy = (samp_q[0] != samp_q[1]) || (samp_q[1] != rxPin);
	wire frameDone = voteNow && state_q == RX_STOP && rxEn;
	wire parBad = (^{shift_q, parBit_q}) != parOdd;
	rx_err_t frameErr;
	assign frameErr.noise = noiseAcc_q | noisy;
	assign frameErr.parity = parEn & parBad;
	assign frameErr.framing = ~vote;
	// A falling edge while idle restarts bit timing, so each frame runs on
	// its own synchronisation rather than on a free running phase.
	always_ff @(posedge clk) begin
		if (rst) begin
			div_q <= 16'h0000;
			phase_q <= 4'h0;
			rxPrev_q <= 1'b1;
		end else begin
			rxPrev_q <= rxPin;
			if (state_q == RX_IDLE && startEdge && rxEn) begin
				div_q <= baud_q;
				phase_q <= 4'h0;
			end else if (tick) begin
				div_q <= baud_q;
				phase_q <= phase_q + 4'h1;
			end else begin
				div_q <= div_q - 16'h0001;
			end
		end
	end
	// Bit-level state machine; after leaving idle on a start edge it moves only at the vote point, or back to idle when the enable bit clears.
	always_ff @(posedge clk) begin
		if (rst) begin
			state_q <= RX_IDLE;
			samp_q <= 2'h0;
			shift_q <= '0;
			bitCnt_q <= 3'h0;
			parBit_q <= 1'b0;
			noiseAcc_q <= 1'b0;
		end else if (!rxEn) begin
			state_q <= RX_IDLE;
		end else begin
			if (tick && phase_q == `SQ_PH_S1) begin
				samp_q[0] <= rxPin;
			end
			if (tick && phase_q == `SQ_PH_S2) begin
				samp_q[1] <= rxPin;
			end
			case (state_q)
				RX_IDLE: begin
					if (startEdge) begin
						state_q <= RX_START;
						noiseAcc_q <= 1'b0;
					end
				end
				RX_START: begin
					// A high vote means the edge was a glitch.
					if (voteNow) begin
						state_q <= vote ? RX_IDLE : RX_DATA;
						bitCnt_q <= 3'h0;
						noiseAcc_q <= noisy;
					end
				end
				RX_DATA: begin
					if (voteNow) begin
						shift_q <= {vote, shift_q[DATA_W-1:1]};
						noiseAcc_q <= noiseAcc_q | noisy;
						bitCnt_q <= bitCnt_q + 3'h1;
						if (bitCnt_q == `SQ_LAST_BIT) begin
							state_q <= parEn ? RX_PARITY : RX_STOP;
						end
					end
				end
				RX_PARITY: begin
					if (voteNow) begin
						parBit_q <= vote;
						noiseAcc_q <= noiseAcc_q | noisy;
						state_q <= RX_STOP;
					end
				end
				RX_STOP: begin
					if (voteNow) begin
						state_q <= RX_IDLE;
					end
				end
				default: begin
					state_q <= RX_IDLE;
				end
			endcase
		end
	end
	// Register writes and side effects of reads.
	wire wrCtrl = wrEn & hitCtrl;
	wire wrBaud = wrEn & hitBaud;
	wire wrQstat = wrEn & hitQstat;
	wire wrTest = wrQstat & testMode;
	wire rdData = rdEn & hitData;
	wire rdQstat = rdEn & hitQstat;
	wire [2:0] qSet;
	wire [2:0] iEvt;
	assign qSet[2] = frameDone && ptr_q == `SQ_PTR_LAST;
	assign qSet[1] = txqTake && txqTakeIdx == `SQ_TXUP_LAST;
	assign qSet[0] = txqTake && txqTakeIdx == `SQ_TXLO_LAST;
	assign iEvt = {|qSet, frameDone & (|frameErr), frameDone};
	always_ff @(posedge clk) begin
		if (rst) begin
			ctrl_q <= 4'h0;
			baud_q <= `SQ_BAUD_RST;
			iMask_q <= 3'h0;
		end else begin
			if (wrCtrl) begin
				ctrl_q <= pwdata[3:0];
			end
			if (wrBaud) begin
				baud_q <= pwdata[15:0];
			end
			if (wrEn && hitImask) begin
				iMask_q <= pwdata[2:0];
			end
		end
	end
	// Holding register and error flags change only at a frame hand-over, the full flag also clears on a data read;
	// the shifter keeps filling meanwhile, which is the double buffer.
	always_ff @(posedge clk) begin
		if (rst) begin
			hold_q <= '0;
			full_q <= 1'b0;
			err_q <= '0;
		end else if (frameDone) begin
			hold_q <= shift_q;
			full_q <= 1'b1;
			err_q <= frameErr;
		end else if (rdData) begin
			full_q <= 1'b0;
		end
	end
	// Queue entries; the write pointer wraps naturally at sixteen.
	always_ff @(posedge clk) begin
		if (frameDone) begin
			rxq[ptr_q] <= shift_q;
		end
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			ptr_q <= 4'h0;
			pend_q <= `SQ_PEND_RST;
		end else if (wrTest) begin
			ptr_q <= pwdata[`SQ_PTR_MSB:`SQ_PTR_LSB];
			pend_q <= pwdata[`SQ_PEND_MSB:`SQ_PEND_LSB];
		end else if (frameDone) begin
			ptr_q <= ptr_q + 4'h1;
			if (pend_q != `SQ_PEND_DONE) begin
				pend_q <= pend_q - 4'h1;
			end
		end
	end
	// One clear sequence per half flag; a new set beats a pending clear.
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_qflag
			wire clr = wrQstat & arm_q[gi] & ~pwdata[`SQ_QF_LSB + gi];
			always_ff @(posedge clk) begin
				if (rst) begin
					qFlag_q[gi] <= 1'b0;
					arm_q[gi] <= 1'b0;
				end else begin
					if (qSet[gi]) begin
						qFlag_q[gi] <= 1'b1;
					end else if (clr) begin
						qFlag_q[gi] <= 1'b0;
					end
					if (rdQstat) begin
						arm_q[gi] <= qFlag_q[gi];
					end else if (wrQstat || !qFlag_q[gi]) begin
						arm_q[gi] <= 1'b0;
					end
				end
			end
		end
	endgenerate
	// Sticky events, write one to clear, set wins.
	always_ff @(posedge clk) begin
		if (rst) begin
			iStat_q <= 3'h0;
		end else if (wrEn && hitIstat) begin
			iStat_q <= (iStat_q & ~pwdata[2:0]) | iEvt;
		end else begin
			iStat_q <= iStat_q | iEvt;
		end
	end
	assign irq = |(iStat_q & iMask_q);
	// Read data is captured in the setup cycle; the shifter has no address.
	wire [31:0] qstatWord = {21'h0, qFlag_q, ptr_q, pend_q};
	wire [31:0] qEntry = {{(32-DATA_W){1'b0}}, rxq[paddr[5:2]]};
	wire [31:0] rdMux = hitCtrl ? {28'h0, ctrl_q} :
		hitBaud ? {16'h0, baud_q} :
		hitData ? {{(32-DATA_W){1'b0}}, hold_q} :
		hitSstat ? {28'h0, err_q, full_q} :
		hitQstat ? qstatWord :
		hitIstat ? {29'h0, iStat_q} :
		hitImask ? {29'h0, iMask_q} :
		hitQueue ? qEntry : 32'h0;
	always_ff @(posedge clk) begin
		if (rst) begin
			prdata_q <= 32'h0;
		end else if (setup) begin
			prdata_q <= rdMux;
		end
	end
	assign prdata = prdata_q;
	// Checks on the block's own behaviour.
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	sequence s_stop;
		state_q == RX_STOP && voteNow && rxEn;
	endsequence
	sequence s_handed;
		full_q && hold_q == $past(shift_q);
	endsequence
	property p_off;
		!rxEn |=> state_q == RX_IDLE;
	endproperty
	a_off: assert property (p_off) else $error("receiver active while disabled");
	property p_hold;
		!$past(frameDone) |-> $stable(hold_q);
	endproperty
	a_hold: assert property (p_hold) else $error("holding data changed outside hand-over");
	property p_done;
		s_stop |=> s_handed;
	endproperty
	a_done: assert property (p_done) else $error("stop bit did not hand frame over");
	property p_full;
		frameDone |=> full_q ##0 state_q == RX_IDLE;
	endproperty
	a_full: assert property (p_full) else $error("full flag missing after frame");
	property p_frame;
		s_stop ##0 !vote |=> err_q.framing;
	endproperty
	a_frame: assert property (p_frame) else $error("framing error not flagged");
	property p_errhold;
		!$past(frameDone) |-> $stable(err_q);
	endproperty
	a_errhold: assert property (p_errhold) else $error("error flags moved between frames");
	property p_bhf;
		frameDone && ptr_q == `SQ_PTR_LAST |=> qFlag_q[2] && ptr_q == 4'h0;
	endproperty
	a_bhf: assert property (p_bhf) else $error("lower half full or wrap wrong");
	property p_txe;
		txqTake && txqTakeIdx == `SQ_TXUP_LAST |=> qFlag_q[1];
	endproperty
	a_txe: assert property (p_txe) else $error("tx upper half empty not set");
	property p_txl;
		txqTake && txqTakeIdx == `SQ_TXLO_LAST |=> qFlag_q[0];
	endproperty
	a_txl: assert property (p_txl) else $error("tx lower half empty not set");
	property p_clr;
		!$past(rst) && $fell(qFlag_q[2]) |-> $past(arm_q[2]) && $past(wrQstat);
	endproperty
	a_clr: assert property (p_clr) else $error("half flag cleared without sequence");
	property p_ptr;
		!$past(frameDone) && !$past(wrTest) |-> $stable(ptr_q) && $stable(pend_q);
	endproperty
	a_ptr: assert property (p_ptr) else $error("pointer or pending moved unprompted");
	property p_sync;
		state_q == RX_START && !voteNow && rxEn |=> state_q == RX_START;
	endproperty
	a_sync: assert property (p_sync) else $error("start left off the vote point");
endmodule

// ==== inc/serial_rx_defines.svh ====
// Register map, field positions, reset values and timing counts of the receiver.
// Notes on behaviour
// - Receiver runs only while enable bit is set.
// - Finished frame held while next one shifts.
// - Serial shifter is never visible to software.
// - Vote samples on timing resynchronised at start edges.
// - Stop bit completes frame; shifter copied out.
// - Full flag sets on that copy.
// - Low stop sample sets framing error flag.
// - Error flags update only at the copy.
// - Lower half full after entries 8-15 filled.
// - Tx upper half empty after entries 0-7 taken.
// - Tx lower half empty after entries 8-15 taken.
// - Half flags clear by read-with-one, then write-zero.
// - Bits 4-7 are write pointer; test-writable only.
// - Bits 0-3 are pending count; test-writable only.
`ifndef SERIAL_RX_DEFINES_SVH
`define SERIAL_RX_DEFINES_SVH
// Byte offsets on the register bus.
`define SQ_CTRL_OFS 8'h00
`define SQ_BAUD_OFS 8'h04
`define SQ_DATA_OFS 8'h08
`define SQ_SSTAT_OFS 8'h0C
`define SQ_QSTAT_OFS 8'h10
`define SQ_ISTAT_OFS 8'h14
`define SQ_IMASK_OFS 8'h18
`define SQ_QBASE_OFS 8'h40
`define SQ_QTOP_OFS 8'h7C
// Control fields.
`define SQ_CTRL_RXEN 0
`define SQ_CTRL_PAREN 1
`define SQ_CTRL_PARODD 2
`define SQ_CTRL_TEST 3
// Queue status fields, bit 0 is the least significant bit of the word.
`define SQ_QF_LSB 8
`define SQ_QF_MSB 10
`define SQ_PTR_LSB 4
`define SQ_PTR_MSB 7
`define SQ_PEND_LSB 0
`define SQ_PEND_MSB 3
// Reset values and fixed counts.
`define SQ_BAUD_RST 16'h00A3
`define SQ_PEND_RST 4'hF
`define SQ_PEND_DONE 4'hF
`define SQ_PTR_LAST 4'hF
`define SQ_TXUP_LAST 4'h7
`define SQ_TXLO_LAST 4'hF
`define SQ_PH_S1 4'h7
`define SQ_PH_S2 4'h8
`define SQ_PH_VOTE 4'h9
`define SQ_LAST_BIT 3'h7
`endif

// ==== inc/serial_rx_pkg.sv ====
// Types shared by the queued serial receiver.
package serial_rx_pkg;
	// Bit-level receive states.
	typedef enum logic [2:0] {
		RX_IDLE = 3'b000,
		RX_START = 3'b001,
		RX_DATA = 3'b010,
		RX_PARITY = 3'b011,
		RX_STOP = 3'b100
	} rx_state_t;
	// Error conditions that travel with one received frame.
	typedef struct packed {
		logic noise;
		logic parity;
		logic framing;
	} rx_err_t;
endpackage

// ==== verification/queued_async_serial_receiver_tb.sv ====
// Self-checking testbench of the queued serial receiver.
`timescale 1ns/10ps
`include "serial_rx_defines.svh"
module queued_async_serial_receiver_tb import serial_rx_pkg::*; ;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic txqTake = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h00000000;
	logic [3:0] txqTakeIdx = 4'h0;
	wire logic [31:0] prdata;
	wire logic pready;
	wire logic pslverr;
	wire logic irq;
	wire logic rxPin;
	int miscompares = 0;
	int comparisons = 0;
	int ptrM = 0; // Model of the receive queue write pointer.
	int noiseAt = -1; // Frame bit that the far side disturbs, or -1 for none.
	logic [31:0] rd;
	logic errSeen;
	logic [3:0] idxT[3] = '{4'h3, 4'h7, 4'hF};
	logic [31:0] expT[3] = '{32'h00000000, 32'h00000200, 32'h00000300};

	// A 40 ns clock period.
	always #20 clk = ~clk;

	queued_async_serial_receiver #(.DATA_W(8)) uut (
		.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .rxPin(rxPin), .txqTake(txqTake), .txqTakeIdx(txqTakeIdx),
		.irq(irq)
	);

	remote_serial_tx far (.clk(clk), .rxPin(rxPin));

	// Prints the counts and the verdict, then ends the run.
	task automatic print_verdict();
		$display("Counts: %0d comparisons, %0d miscompares", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// Compares one value seen against the value expected.
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// One APB transfer; an idle cycle follows so psel is never driven twice at one edge.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		logic gotReady;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 8);
		gotReady = pready;
		rd = prdata;
		errSeen = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
		if (gotReady !== 1'b1) begin
			miscompares++;
			print_verdict();
		end
	endtask

	// Reads a register and compares the masked word.
	task automatic rdchk(input string name, input logic [7:0] a, input logic [31:0] mask,
		input logic [31:0] exp);
		apb(1'b0, a, 32'h00000000);
		check(name, rd & mask, exp);
	endtask

	// Sends a random byte and checks status; holding data, queue entry and pointer only when the expected status is nonzero.
	task automatic frame(input int par, input bit flip, input bit stop, input logic [31:0] expS);
		logic [31:0] v;
		v = $urandom;
		far.sendFrame(v[7:0], par, flip, stop, 32, noiseAt);
		repeat (2) @(posedge clk);
		rdchk("status", `SQ_SSTAT_OFS, 32'h0000000F, expS);
		if (expS !== 32'h00000000) begin
			rdchk("data", `SQ_DATA_OFS, 32'h000000FF, {24'h0, v[7:0]});
			rdchk("entry", 8'(`SQ_QBASE_OFS + 4 * ptrM), 32'h000000FF, {24'h0, v[7:0]});
			ptrM = (ptrM + 1) % 16;
			rdchk("pointer", `SQ_QSTAT_OFS, 32'h000000F0, 32'(ptrM << 4));
		end
	endtask

	// Main sequence: reset, map, reception, errors, queue status.
	initial begin
		void'($urandom(59720));
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rdchk("qstat", `SQ_QSTAT_OFS, 32'hFFFFFFFF, 32'h0000000F);
		rdchk("baud", `SQ_BAUD_OFS, 32'hFFFFFFFF, 32'h000000A3);
		rdchk("sstat", `SQ_SSTAT_OFS, 32'hFFFFFFFF, 32'h00000000);
		apb(1'b0, 8'h30, 32'h00000000);
		check("unmapped", {31'h0, errSeen}, 32'h00000001);
		$display("done: reset and map");
		// A bit time of 32 cycles keeps frames short.
		apb(1'b1, `SQ_BAUD_OFS, 32'h00000001);
		frame(0, 1'b0, 1'b1, 32'h00000000);
		apb(1'b1, `SQ_CTRL_OFS, 32'h00000001);
		frame(0, 1'b0, 1'b1, 32'h00000001);
		check("irq", {31'h0, irq}, 32'h00000000);
		apb(1'b1, `SQ_IMASK_OFS, 32'h00000001);
		check("irq", {31'h0, irq}, 32'h00000001);
		apb(1'b1, `SQ_ISTAT_OFS, 32'h00000007);
		check("irq", {31'h0, irq}, 32'h00000000);
		$display("done: reception and interrupt");
		frame(0, 1'b0, 1'b0, 32'h00000003);
		apb(1'b1, `SQ_CTRL_OFS, 32'h00000003);
		frame(1, 1'b0, 1'b1, 32'h00000001);
		frame(1, 1'b1, 1'b1, 32'h00000005);
		apb(1'b1, `SQ_CTRL_OFS, 32'h00000007);
		frame(2, 1'b0, 1'b1, 32'h00000001);
		// One wrong sample in data bit 1 is outvoted but must raise the noise flag.
		noiseAt = 2;
		frame(2, 1'b0, 1'b1, 32'h00000009);
		noiseAt = -1;
		$display("done: error flags");
		// Pointer and pending ignore writes outside test mode.
		apb(1'b1, `SQ_QSTAT_OFS, 32'h000000E3);
		rdchk("pointer", `SQ_QSTAT_OFS, 32'h000000F0, 32'(ptrM << 4));
		apb(1'b1, `SQ_CTRL_OFS, 32'h00000009);
		apb(1'b1, `SQ_QSTAT_OFS, 32'h000000E3);
		rdchk("testwr", `SQ_QSTAT_OFS, 32'h000000FF, 32'h000000E3);
		ptrM = 14;
		apb(1'b1, `SQ_CTRL_OFS, 32'h00000001);
		frame(0, 1'b0, 1'b1, 32'h00000001);
		frame(0, 1'b0, 1'b1, 32'h00000001);
		rdchk("halffull", `SQ_QSTAT_OFS, 32'h000007FF, 32'h00000401);
		// A write without a fresh read must not clear the flag.
		apb(1'b1, `SQ_QSTAT_OFS, 32'h00000400);
		apb(1'b1, `SQ_QSTAT_OFS, 32'h00000000);
		rdchk("noclear", `SQ_QSTAT_OFS, 32'h00000400, 32'h00000400);
		apb(1'b1, `SQ_QSTAT_OFS, 32'h00000000);
		rdchk("cleared", `SQ_QSTAT_OFS, 32'h00000400, 32'h00000000);
		$display("done: receive queue");
		for (int i = 0; i < 3; i++) begin
			txqTake <= 1'b1;
			txqTakeIdx <= idxT[i];
			@(posedge clk);
			txqTake <= 1'b0;
			@(posedge clk);
			rdchk("txq", `SQ_QSTAT_OFS, 32'h00000300, expT[i]);
		end
		apb(1'b1, 8'h41, 32'h00000055);
		check("unaligned", {31'h0, errSeen}, 32'h00000001);
		$display("done: transmit queue status");
		print_verdict();
	end
endmodule

// ==== verification/remote_serial_tx.sv ====
// Remote asynchronous transmitter model that drives the receive line.
`timescale 1ns/10ps
module remote_serial_tx (
	input wire logic clk,
	output logic rxPin
);
	// The line idles high outside frames, as a real idle line does.
	initial rxPin = 1'b1;

	// Sends one frame LSB first; parMode 0 is none, 1 even, 2 odd.
	// A low stopLevel breaks the frame on purpose, for the framing test only.
	// A noiseBit of zero or more disturbs that bit of the frame; -1 sends it clean.
	task automatic sendFrame(input logic [7:0] data, input int parMode, input bit flipPar,
		input bit stopLevel, input int bitCycles, input int noiseBit);
		logic q[$];
		logic par;
		q.push_back(1'b0);
		for (int i = 0; i < 8; i++) begin
			q.push_back(data[i]);
		end
		par = (parMode == 1) ? ^data : ~^data;
		if (parMode != 0) begin
			q.push_back(par ^ flipPar);
		end
		q.push_back(stopLevel);
		// Each bit is held a whole bit time, changed only just after an edge.
		// A disturbed bit is inverted briefly, so only one of its three samples is wrong.
		foreach (q[i]) begin
			rxPin <= q[i];
			if (i == noiseBit) begin
				repeat (12) @(posedge clk);
				rxPin <= ~q[i];
				repeat (6) @(posedge clk);
				rxPin <= q[i];
				repeat (bitCycles - 18) @(posedge clk);
			end else begin
				repeat (bitCycles) @(posedge clk);
			end
		end
		rxPin <= 1'b1;
	endtask
endmodule
